// [src/ucg_pkg.sv]
/*
 * Constants, mode type and carriers of the serial clock generator.
 * Assumes one system clock and an 8-bit register port.
 */
// Overview of operation
// - Four clock modes yield transmitter and receiver base clocks.
// - Mode select bit one picks synchronous operation, zero asynchronous.
// - In synchronous operation pin direction output is master, input slave.
// - Transfer clock pin is ignored entirely in asynchronous modes.
// - Baud counter decrements each clock, reloads at zero or low write.
// - One baud pulse per zero, rate is clock over divisor plus one.
// - Transmitter clock is baud divided by 16, 8 or 2 by mode, or the pin change edge in slave.
// - Receiver takes undivided baud, or both pin edges in slave; recovery uses 2, 8 or 16 states.
// - Divisor is twelve bits made of high and low registers.
// - Double speed applies only asynchronously; software keeps it zero else.
// - Double speed gives 8 receiver samples and transmitter divide by 8.
// - Slave clock passes synchroniser and edge detector, two clocks late.
// - Sampling happens on the edge opposite to the output change edge.
// - Polarity zero: change on rising, sample on falling; one reverses.
// - Internal baud clocks async and master; master drives pin out.

package ucg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 3;
    localparam int          DIV_W        = 12;
    localparam int          DIV_HIGH_W   = 4;
    localparam logic [2:0]  ADDR_CTRL_A  = 3'h0;
    localparam logic [2:0]  ADDR_CTRL_C  = 3'h1;
    localparam logic [2:0]  ADDR_DIV_LO  = 3'h2;
    localparam logic [2:0]  ADDR_DIV_HI  = 3'h3;
    localparam logic [2:0]  ADDR_PIN     = 3'h4;
    localparam logic [2:0]  ADDR_STATUS  = 3'h5;

    // field positions
    localparam int BIT_DOUBLE_SPEED = 1;  // in control_status_a
    localparam int BIT_SYNC_MODE    = 6;  // in control_status_c
    localparam int BIT_POLARITY     = 0;  // in control_status_c
    localparam int BIT_PIN_DIR      = 0;  // in pin control
    localparam int BIT_POWER_OFF    = 1;  // in pin control

    // reset values
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [3:0] RST_DIV_HI  = 4'h0;
    localparam logic [7:0] RST_PIN     = 8'h00;

    // ------------------------------------------------------------------
    // divider and recovery figures
    // ------------------------------------------------------------------
    localparam logic [4:0] TX_DIV_NORMAL = 5'h10;
    localparam logic [4:0] TX_DIV_DOUBLE = 5'h08;
    localparam logic [4:0] TX_DIV_MASTER = 5'h02;
    localparam logic [4:0] RX_ST_NORMAL  = 5'h10;
    localparam logic [4:0] RX_ST_DOUBLE  = 5'h08;
    localparam logic [4:0] RX_ST_SYNC    = 5'h02;

    // one-hot clock modes
    typedef enum logic [3:0] {
        MODE_ASYNC_NORMAL = 4'b0001,
        MODE_ASYNC_DOUBLE = 4'b0010,
        MODE_SYNC_MASTER  = 4'b0100,
        MODE_SYNC_SLAVE   = 4'b1000
    } ucg_mode_type;

    // decoded configuration
    typedef struct packed {
        logic             power_off;
        logic             pin_dir;
        logic             polarity;
        logic             sync_mode;
        logic             double_speed;
        logic [DIV_W-1:0] divisor;
    } ucg_cfg_type;

    // one-cycle enables to transmitter and receiver
    typedef struct packed {
        logic tx_clk;
        logic rx_clk;
        logic change;
        logic sample;
    } ucg_strobe_type;

endpackage

// [src/ucg_baud_counter.sv]
/*
 * Baud down-counter giving one-cycle pulses.
 * Assumes run and reload are on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ucg_baud_counter #(
    parameter int DIV_W = 12
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             run,
    input  wire logic             reload,
    input  wire logic [DIV_W-1:0] divisor,
    // output enable
    output logic                  tick
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
        $error("ucg_baud_counter: DIV_W out of range");
    end

    logic [DIV_W-1:0] count;
    logic             armed;
    wire              at_zero = (count == '0);

    // armed keeps the reset-time zero from producing a pulse
    assign tick = at_zero & armed & run;

    // count down, reload at zero or on a low-byte write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            armed <= 1'b0;
        end else if (!run) begin
            count <= '0;
            armed <= 1'b0;
        end else if (reload || at_zero) begin
            count <= divisor;
            armed <= 1'b1;
        end else begin
            count <= count - DIV_W'(1);
        end
    end

endmodule // ucg_baud_counter

`default_nettype wire

// [src/ucg_edge_sync.sv]
/*
 * Synchroniser and edge detector of the transfer clock pin.
 * Assumes pin_in is asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module ucg_edge_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin side
    input  wire logic pin_in,
    // detected level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta;
    logic sync;
    logic prev;

    // meta feeds only sync; prev holds the last clean level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    // edge detection on the settled copy
    assign level = sync;
    assign rise  = sync & ~prev;
    assign fall  = ~sync & prev;

endmodule // ucg_edge_sync

`default_nettype wire

// [src/ucg_clock_gen.sv]
/*
 * Serial clock generator: registers, baud counter, dividers, edges.
 * Assumes one clock MCLK, async RESETN, a zero-wait register master.
 */
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module ucg_clock_gen #(
    parameter int DIV_W = ucg_pkg::DIV_W
) (
    // clock and reset
    input  wire logic                       MCLK,
    input  wire logic                       RESETN,
    // register port
    input  wire logic [ucg_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [ucg_pkg::DATA_W-1:0] WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    output logic      [ucg_pkg::DATA_W-1:0] RDATA,
    // transfer clock pin
    input  wire logic                       XCK_I,
    output logic                            XCK_O,
    output logic                            XCK_OE,
    // enables to transmitter and receiver
    output logic                            TX_CLK,
    output logic                            RX_CLK,
    output logic                            SYNC_CHANGE,
    output logic                            SYNC_SAMPLE,
    // receiver recovery state
    output logic      [4:0]                 RX_STATES,
    output logic      [3:0]                 RX_PHASE
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (DIV_W != ucg_pkg::DIV_W) begin : g_bad_div
        $error("ucg_clock_gen: divisor width must be 12");
    end

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // assert at once, release two edges later so no flop sees a runt
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    logic [7:0]                       ctrl_a;
    logic [7:0]                       ctrl_c;
    logic [7:0]                       div_low;
    logic [ucg_pkg::DIV_HIGH_W-1:0]   div_high;
    logic [7:0]                       pin_ctrl;

    wire wr_ctrl_a  = WR & (ADDR == ucg_pkg::ADDR_CTRL_A);
    wire wr_ctrl_c  = WR & (ADDR == ucg_pkg::ADDR_CTRL_C);
    wire wr_div_lo  = WR & (ADDR == ucg_pkg::ADDR_DIV_LO);
    wire wr_div_hi  = WR & (ADDR == ucg_pkg::ADDR_DIV_HI);
    wire wr_pin     = WR & (ADDR == ucg_pkg::ADDR_PIN);

    // control and divisor registers
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a   <= ucg_pkg::RST_BYTE;
            ctrl_c   <= ucg_pkg::RST_BYTE;
            div_low  <= ucg_pkg::RST_BYTE;
            div_high <= ucg_pkg::RST_DIV_HI;
            pin_ctrl <= ucg_pkg::RST_PIN;
        end else begin
            if (wr_ctrl_a) ctrl_a <= WDATA;
            if (wr_ctrl_c) ctrl_c <= WDATA;
            if (wr_div_lo) div_low <= WDATA;
            if (wr_div_hi) div_high <= WDATA[ucg_pkg::DIV_HIGH_W-1:0];
            if (wr_pin) pin_ctrl <= WDATA;
        end
    end

    // ------------------------------------------------------------------
    // configuration and mode selection
    // ------------------------------------------------------------------
    ucg_pkg::ucg_cfg_type  cfg;
    ucg_pkg::ucg_mode_type mode;

    // high nibble and low byte form the twelve-bit divisor
    assign cfg = '{
        power_off:    pin_ctrl[ucg_pkg::BIT_POWER_OFF],
        pin_dir:      pin_ctrl[ucg_pkg::BIT_PIN_DIR],
        polarity:     ctrl_c[ucg_pkg::BIT_POLARITY],
        sync_mode:    ctrl_c[ucg_pkg::BIT_SYNC_MODE],
        double_speed: ctrl_a[ucg_pkg::BIT_DOUBLE_SPEED],
        divisor:      {div_high, div_low}
    };

    // double speed is ignored in synchronous operation
    wire ds_eff = cfg.double_speed & ~cfg.sync_mode;

    // mode from select bit, then pin direction or double speed
    assign mode = cfg.sync_mode
        ? (cfg.pin_dir ? ucg_pkg::MODE_SYNC_MASTER
                       : ucg_pkg::MODE_SYNC_SLAVE)
        : (ds_eff ? ucg_pkg::MODE_ASYNC_DOUBLE
                  : ucg_pkg::MODE_ASYNC_NORMAL);

    wire is_master = (mode == ucg_pkg::MODE_SYNC_MASTER);
    wire is_slave  = (mode == ucg_pkg::MODE_SYNC_SLAVE);
    wire active    = ~cfg.power_off;

    // ------------------------------------------------------------------
    // baud rate generator
    // ------------------------------------------------------------------
    logic baud_tick;
    // internal source for async and master; idle in slave
    wire  baud_run = active & ~is_slave;

    ucg_baud_counter #(
        .DIV_W   (DIV_W)
    ) u_baud (
        .clk     (MCLK),
        .rst_n   (rst_n),
        .run     (baud_run),
        .reload  (wr_div_lo),
        .divisor (cfg.divisor),
        .tick    (baud_tick)
    );

    // ------------------------------------------------------------------
    // external clock synchroniser
    // ------------------------------------------------------------------
    logic xck_rise;
    logic xck_fall;

    ucg_edge_sync u_xck (
        .clk    (MCLK),
        .rst_n  (rst_n),
        .pin_in (XCK_I),
        .level  (),
        .rise   (xck_rise),
        .fall   (xck_fall)
    );

    // pin edges count only in slave mode
    wire slave_rise = xck_rise & is_slave & active;
    wire slave_fall = xck_fall & is_slave & active;

    // ------------------------------------------------------------------
    // master transfer clock
    // ------------------------------------------------------------------
    logic xck_out;

    // a toggle per baud pulse halves the rate
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            xck_out <= 1'b0;
        end else if (!is_master || !active) begin
            xck_out <= 1'b0;
        end else if (baud_tick) begin
            xck_out <= ~xck_out;
        end
    end

    wire master_rise = baud_tick & is_master & ~xck_out;
    wire master_fall = baud_tick & is_master & xck_out;

    // ------------------------------------------------------------------
    // synchronous edge selection
    // ------------------------------------------------------------------
    wire edge_rise = master_rise | slave_rise;
    wire edge_fall = master_fall | slave_fall;

    // polarity zero: change on rising, sample on falling; one swaps
    wire sync_change = cfg.polarity ? edge_fall : edge_rise;
    // sampling on the edge opposite the change edge
    wire sync_sample = cfg.polarity ? edge_rise : edge_fall;

    // ------------------------------------------------------------------
    // transmitter divider for asynchronous modes
    // ------------------------------------------------------------------
    logic [4:0] tx_cnt;
    logic [4:0] tx_len;

    // normal divides by sixteen, double speed by eight
    assign tx_len = ds_eff ? ucg_pkg::TX_DIV_DOUBLE
                           : ucg_pkg::TX_DIV_NORMAL;
    wire   tx_wrap  = (tx_cnt >= tx_len - 5'h01);
    wire   async_tx = baud_tick & ~cfg.sync_mode & tx_wrap;

    // counts baud pulses; wraps at the next pulse if the length shrinks mid-count
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt <= 5'h00;
        end else if (cfg.sync_mode || !active) begin
            tx_cnt <= 5'h00;
        end else if (baud_tick) begin
            tx_cnt <= tx_wrap ? 5'h00 : tx_cnt + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // receiver recovery phase
    // ------------------------------------------------------------------
    logic [4:0] rx_states;
    logic [3:0] rx_phase;

    // state count from the decoded mode
    always_comb begin
        case (mode)
            ucg_pkg::MODE_ASYNC_NORMAL: rx_states = ucg_pkg::RX_ST_NORMAL;
            ucg_pkg::MODE_ASYNC_DOUBLE: rx_states = ucg_pkg::RX_ST_DOUBLE;
            ucg_pkg::MODE_SYNC_MASTER:  rx_states = ucg_pkg::RX_ST_SYNC;
            ucg_pkg::MODE_SYNC_SLAVE:   rx_states = ucg_pkg::RX_ST_SYNC;
            default:                    rx_states = ucg_pkg::RX_ST_NORMAL;
        endcase
    end

    // receiver base: undivided baud or either slave edge
    wire rx_base = (baud_tick & ~is_slave)
                 | slave_rise | slave_fall;
    wire rx_last = ({1'b0, rx_phase} >= rx_states - 5'h01);

    // phase wraps at the state count so a mode change recovers at once
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_phase <= 4'h0;
        end else if (!active) begin
            rx_phase <= 4'h0;
        end else if (rx_base) begin
            rx_phase <= rx_last ? 4'h0 : rx_phase + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // strobe registers
    // ------------------------------------------------------------------
    ucg_pkg::ucg_strobe_type next_strobe;
    ucg_pkg::ucg_strobe_type strobe;

    // sync transmitter clock is the change edge, in master already baud over two
    assign next_strobe = '{
        tx_clk: async_tx | sync_change,
        rx_clk: rx_base,
        change: sync_change,
        sample: sync_sample
    };

    // one register stage keeps the outputs glitch free
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            strobe <= '0;
        end else begin
            strobe <= next_strobe;
        end
    end

    // ------------------------------------------------------------------
    // pin drive and read-back
    // ------------------------------------------------------------------
    // only master drives the pin
    assign XCK_O  = xck_out;
    assign XCK_OE = is_master & active;

    logic [7:0] status;
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;

    // status shows the live mode and recovery phase
    assign status = {rx_phase, mode};

    // unmapped offsets read as zero
    assign rd_mux =
        (ADDR == ucg_pkg::ADDR_CTRL_A) ? ctrl_a :
        (ADDR == ucg_pkg::ADDR_CTRL_C) ? ctrl_c :
        (ADDR == ucg_pkg::ADDR_DIV_LO) ? div_low :
        (ADDR == ucg_pkg::ADDR_DIV_HI) ? {4'h0, div_high} :
        (ADDR == ucg_pkg::ADDR_PIN)    ? pin_ctrl :
        (ADDR == ucg_pkg::ADDR_STATUS) ? status : 8'h00;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= RD ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RDATA       = rdata_q;
    assign TX_CLK      = strobe.tx_clk;
    assign RX_CLK      = strobe.rx_clk;
    assign SYNC_CHANGE = strobe.change;
    assign SYNC_SAMPLE = strobe.sample;
    assign RX_STATES   = rx_states;
    assign RX_PHASE    = rx_phase;

endmodule // ucg_clock_gen

`default_nettype wire

// [tb/ucg_peer.sv]
/*
 * Serial peer: clocks the pin in synchronous slave mode.
 * Assumes the bench drives run and half_ns.
 */
`timescale 1ns/100ps
`default_nettype none

module ucg_peer (
    // control from the bench
    input  wire logic        run,
    input  wire logic [15:0] half_ns,
    // transfer clock towards the device
    output logic             xck
);
    // ------------------------------------------------------------
    // clock bursts
    // ------------------------------------------------------------
    // odd offset keeps edges off the MCLK edges; a burst ends low
    initial begin
        xck = 1'b0;
        forever begin
            wait (run);
            #37;
            #(half_ns) xck = 1'b1;
            #(half_ns) xck = 1'b0;
        end
    end
endmodule // ucg_peer

`default_nettype wire

// [tb/ucg_clock_gen_checker.sv]
/*
 * Checker of the clock generator, bound to its top module.
 * Assumes all configuration arrives by register writes.
 */
`timescale 1ns/100ps
`default_nettype none

module ucg_chk (
    // clock, reset and register writes
    input wire logic       MCLK,
    input wire logic       RESETN,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    // pin and enables
    input wire logic       XCK_I,
    input wire logic       XCK_O,
    input wire logic       XCK_OE,
    input wire logic       TX_CLK,
    input wire logic       RX_CLK,
    input wire logic       SYNC_CHANGE,
    input wire logic       SYNC_SAMPLE,
    input wire logic [4:0] RX_STATES
);
    // ------------------------------------------------------------
    // shadow configuration and pulse spacing
    // ------------------------------------------------------------
    logic        sy, dir, pol, dbl, off, wr_d, pv, tv;
    logic [11:0] dv;
    logic [12:0] gap;
    logic [4:0]  rxn;
    wire  logic  slave = sy & ~dir & ~off;
    // a write restarts the spacing measure
    wire  logic  quiet = ~(WR | wr_d | off | slave);

    // configuration as last written
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            {sy, dir, pol, dbl, off, dv} <= '0;
        end else if (WR) begin
            case (ADDR)
                ucg_pkg::ADDR_CTRL_A: dbl <= WDATA[ucg_pkg::BIT_DOUBLE_SPEED];
                ucg_pkg::ADDR_CTRL_C: begin
                    sy  <= WDATA[ucg_pkg::BIT_SYNC_MODE];
                    pol <= WDATA[ucg_pkg::BIT_POLARITY];
                end
                ucg_pkg::ADDR_DIV_LO: dv[7:0] <= WDATA;
                ucg_pkg::ADDR_DIV_HI: dv[11:8] <= WDATA[3:0];
                ucg_pkg::ADDR_PIN: begin
                    dir <= WDATA[ucg_pkg::BIT_PIN_DIR];
                    off <= WDATA[ucg_pkg::BIT_POWER_OFF];
                end
                default: ;
            endcase
        end
    end

    // cycles and receiver pulses since the last pulse
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            {wr_d, pv, tv, gap, rxn} <= '0;
        end else begin
            wr_d <= WR;
            gap  <= RX_CLK ? 13'h0000 : gap + 13'h0001;
            rxn  <= TX_CLK ? 5'h00 : rxn + 5'(RX_CLK);
            pv   <= quiet & (pv | RX_CLK);
            tv   <= quiet & (tv | TX_CLK);
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    property p_oe;
        XCK_OE == (sy & dir & ~off);
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin enable wrong");
    property p_states;
        RX_STATES == (sy ? 5'h02 : (dbl ? 5'h08 : 5'h10));
    endproperty
    a_states: assert property (p_states)
        else $error("recovery state count wrong");
    property p_period;
        RX_CLK && pv |-> gap == {1'b0, dv};
    endproperty
    a_period: assert property (p_period)
        else $error("baud pulse spacing wrong");
    property p_ratio;
        TX_CLK && tv |-> (rxn + 5'(RX_CLK)) ==
            (sy ? 5'h02 : (dbl ? 5'h08 : 5'h10));
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("transmit divide ratio wrong");
    property p_rise;
        slave && $rose(XCK_I) |->
            ##3 RX_CLK && (pol ? SYNC_SAMPLE : SYNC_CHANGE);
    endproperty
    a_rise: assert property (p_rise)
        else $error("slave rise late");
    property p_fall;
        slave && $fell(XCK_I) |->
            ##3 RX_CLK && (pol ? SYNC_CHANGE : SYNC_SAMPLE);
    endproperty
    a_fall: assert property (p_fall)
        else $error("slave fall late");
    property p_opp;
        sy && $past(sy) |-> !(SYNC_CHANGE && SYNC_SAMPLE)
            && TX_CLK == SYNC_CHANGE
            && (!(SYNC_CHANGE && dir) || XCK_O != pol);
    endproperty
    a_opp: assert property (p_opp)
        else $error("sync edges wrong");
    property p_async;
        !sy && !$past(sy) |-> !SYNC_CHANGE && !SYNC_SAMPLE && !XCK_O;
    endproperty
    a_async: assert property (p_async)
        else $error("pin active in async mode");

    c_slave: cover property (slave && SYNC_SAMPLE);
    c_master: cover property (sy && dir && TX_CLK);
    c_double: cover property (dbl && !sy && TX_CLK);
endmodule // ucg_chk

bind ucg_clock_gen ucg_chk u_chk (
    .MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .XCK_I(XCK_I), .XCK_O(XCK_O), .XCK_OE(XCK_OE), .TX_CLK(TX_CLK),
    .RX_CLK(RX_CLK), .SYNC_CHANGE(SYNC_CHANGE),
    .SYNC_SAMPLE(SYNC_SAMPLE), .RX_STATES(RX_STATES));

`default_nettype wire

// [tb/tb.sv]
/*
 * Bench of the serial clock generator.
 * Assumes the peer and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        mclk, resetn, wr_s, rd_s, run, xck_o, xck_oe, peer_xck;
    logic        tx_clk, rx_clk, sync_change, sync_sample;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [4:0]  rx_states;
    logic [3:0]  rx_phase;
    logic [15:0] half_ns;
    int          err_count, n_tests, cyc, rises, p, s[4], cnt[4], r0;
    // pin level: device drives while enabled
    wire  logic  xck_i = xck_oe ? xck_o : peer_xck;
    wire  [3:0]  pul = {sync_sample, sync_change, rx_clk, tx_clk};

    ucg_clock_gen dut (
        .MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .XCK_I(xck_i),
        .XCK_O(xck_o), .XCK_OE(xck_oe), .TX_CLK(tx_clk),
        .RX_CLK(rx_clk), .SYNC_CHANGE(sync_change),
        .SYNC_SAMPLE(sync_sample), .RX_STATES(rx_states),
        .RX_PHASE(rx_phase));
    ucg_peer peer (.run(run), .half_ns(half_ns), .xck(peer_xck));

    // ------------------------------------------------------------
    // clock, pulse counters, hang guard
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge peer_xck) rises++;
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) cnt[i] += int'(pul[i]);
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            print_verdict;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] m, e);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        @(negedge mclk);
        chk(16'(rdata & m), 16'(e));
    endtask
    // cycles between two pulses of one enable
    task automatic per(input int w, input int e);
        int n;
        repeat (2) begin
            n = 0;
            @(negedge mclk);
            while (pul[w] !== 1'b1 && n < 9000) begin
                n++;
                @(negedge mclk);
            end
        end
        chk(16'(n + 1), 16'(e));
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, wr_s, rd_s, run, addr, wdata} = '0;
        half_ns = 16'd300;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(3'h0, 8'hff, 8'h00);
        rd(3'h5, 8'h0f, 8'h01);
        rd(3'h6, 8'hff, 8'h00);
        chk(16'(rx_states), 16'd16);
        wr(3'h3, 8'h01);
        wr(3'h2, 8'h02);
        rd(3'h3, 8'h0f, 8'h01);
        per(1, 259);
        per(0, 4144);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h04);
        per(1, 5);
        per(0, 80);
        // peer clocks the pin while async: no effect
        run <= 1'b1;
        wr(3'h0, 8'h02);
        per(0, 40);
        chk(16'(xck_oe), 16'd0);
        chk(16'(rx_states), 16'd8);
        run <= 1'b0;
        repeat (20) @(posedge mclk);
        // master, double speed left set and ignored
        wr(3'h4, 8'h01);
        wr(3'h1, 8'h40);
        per(0, 10);
        chk(16'(xck_oe), 16'd1);
        rd(3'h5, 8'h0f, 8'h04);
        chk(16'(rx_states), 16'd2);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h00);
        // powered off: no receiver enable, phase held at zero
        wr(3'h4, 8'h02);
        repeat (5) @(posedge mclk);
        s = cnt;
        repeat (100) @(posedge mclk);
        chk(16'(cnt[1] - s[1]), 16'd0);
        chk(16'(rx_phase), 16'd0);
        wr(3'h4, 8'h00);
        // slave, both polarities
        for (p = 0; p < 2; p++) begin
            wr(3'h1, 8'h40 | 8'(p));
            rd(3'h5, 8'h0f, 8'h08);
            half_ns <= p ? 16'd230 : 16'd500;
            s = cnt;
            r0 = rises;
            run <= 1'b1;
            repeat (150) @(posedge mclk);
            run <= 1'b0;
            repeat (30) @(posedge mclk);
            chk(16'(cnt[2] - s[2]), 16'(rises - r0));
            chk(16'(cnt[3] - s[3]), 16'(rises - r0));
            chk(16'(cnt[1] - s[1]), 16'(2 * (rises - r0)));
        end
        print_verdict;
    end
endmodule // tb

`default_nettype wire
